//--- rtl/ppc_map.svh
// Address map, reset value and bit positions of the port PHY control block.
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
`define PPC_ADDR_W        8
`define PPC_DATA_W        16
`define PPC_OFS_PORT_CTRL 8'h02
`define PPC_OFS_PHY_BCR   8'h40
`define PPC_OFS_PHY_ANAR  8'h48
`define PPC_RST_CTRL      16'h009f
`define PPC_ZERO16        16'h0000
`define PPC_LED_BLANK     4'hf
`define PPC_P_LED_OFF     15
`define PPC_P_TX_DIS      14
`define PPC_P_RESTART     13
`define PPC_P_MDIX_OFF    10
`define PPC_P_PWR_DOWN    11
`define PPC_P_FORCE_MDIX  9
`define PPC_P_ADV_HI      4
`define PPC_P_ADV_LO      0
`define PPC_B_LED_OFF     0
`define PPC_B_TX_DIS      1
`define PPC_B_RSVD        2
`define PPC_B_MDIX_OFF    3
`define PPC_B_FORCE_MDIX  4
`define PPC_B_FORCE_FULL  8
`define PPC_B_RESTART     9
`define PPC_B_PWR_DOWN    11
`define PPC_B_AN_EN       12
`define PPC_B_FORCE_100   13
`define PPC_B_FAR_LOOP    14
`define PPC_A_10HD        5
`define PPC_A_10FD        6
`define PPC_A_100HD       7
`define PPC_A_100FD       8
`define PPC_A_PAUSE       10
`endif

//--- rtl/ppc_pkg.sv
// Types shared by the port PHY control block.
`default_nettype none
package ppc_pkg;
  typedef struct packed {
    logic led_off;
    logic tx_dis;
    logic restart_an;
    logic rsvd12;
    logic power_down;
    logic mdix_auto_off;
    logic force_mdix;
    logic far_loop;
    logic an_en;
    logic force_100;
    logic force_full;
    logic adv_pause;
    logic adv_100fd;
    logic adv_100hd;
    logic adv_10fd;
    logic adv_10hd;
  } ppc_ctrl_t;
  typedef struct packed {
    logic pause;
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
  } ppc_adv_t;
  typedef struct packed {
    logic failed;
    logic speed_100;
    logic duplex_full;
  } ppc_an_t;
  typedef enum logic [3:0] {
    PPC_SEL_NONE = 4'b0001,
    PPC_SEL_PORT = 4'b0010,
    PPC_SEL_BCR  = 4'b0100,
    PPC_SEL_ANAR = 4'b1000
  } ppc_sel_t;
endpackage
`default_nettype wire

//--- rtl/ppc_phy_ctrl.sv
// Port 1 PHY control register with its two PHY-bank alias views.
`include "ppc_map.svh"
`default_nettype none
module ppc_phy_ctrl #(
  parameter int LED_W = 4,
  parameter int SYM_W = 4
) (
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     ce,
  input  wire logic [`PPC_ADDR_W-1:0]   addr,
  input  wire logic [`PPC_DATA_W-1:0]   wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [`PPC_DATA_W-1:0]   rdata,
  input  wire logic [LED_W-1:0]         led_in,
  output logic      [LED_W-1:0]         port1_led_out,
  input  wire ppc_pkg::ppc_an_t         an_result,
  output logic                          tx_disable,
  output logic                          restart_an,
  output logic                          power_down,
  output logic                          auto_mdix_off,
  output logic                          force_mdix,
  output logic                          an_enable,
  output logic                          link_speed_100,
  output logic                          link_duplex_full,
  output ppc_pkg::ppc_adv_t             advertise,
  input  wire logic [SYM_W-1:0]         second_port_receive_pair,
  input  wire logic [SYM_W-1:0]         port2_tx_normal,
  output logic      [SYM_W-1:0]         second_port_transmit_pair
);

  ppc_pkg::ppc_ctrl_t               ctrl_reg;
  ppc_pkg::ppc_ctrl_t               ctrl_next;
  logic               [`PPC_DATA_W-1:0] rdata_reg;
  logic               [`PPC_DATA_W-1:0] rdata_next;
  logic                             restart_reg;
  logic               [LED_W-1:0]   led_reg;
  logic               [SYM_W-1:0]   tx_pair_reg;
  logic                             speed_reg;
  logic                             duplex_reg;
  ppc_pkg::ppc_sel_t                sel;

  // Address decode is shared by the write path and the read path.
  function automatic ppc_pkg::ppc_sel_t decode(input logic [`PPC_ADDR_W-1:0] a);
    begin
      case (a)
        `PPC_OFS_PORT_CTRL: decode = ppc_pkg::PPC_SEL_PORT;
        `PPC_OFS_PHY_BCR:   decode = ppc_pkg::PPC_SEL_BCR;
        `PPC_OFS_PHY_ANAR:  decode = ppc_pkg::PPC_SEL_ANAR;
        default:            decode = ppc_pkg::PPC_SEL_NONE;
      endcase
    end
  endfunction

  // Basic control view of the shared storage; unused bits read as zero.
  function automatic logic [`PPC_DATA_W-1:0] bcr_view(input ppc_pkg::ppc_ctrl_t c);
    logic [`PPC_DATA_W-1:0] v;
    begin
      v = `PPC_ZERO16;
      v[`PPC_B_LED_OFF]    = c.led_off;
      v[`PPC_B_TX_DIS]     = c.tx_dis;
      v[`PPC_B_RSVD]       = c.rsvd12;
      v[`PPC_B_MDIX_OFF]   = c.mdix_auto_off;
      v[`PPC_B_FORCE_MDIX] = c.force_mdix;
      v[`PPC_B_FORCE_FULL] = c.force_full;
      v[`PPC_B_RESTART]    = c.restart_an;
      v[`PPC_B_PWR_DOWN]   = c.power_down;
      v[`PPC_B_AN_EN]      = c.an_en;
      v[`PPC_B_FORCE_100]  = c.force_100;
      v[`PPC_B_FAR_LOOP]   = c.far_loop;
      bcr_view = v;
    end
  endfunction

  // Advertisement view of the shared storage; unused bits read as zero.
  function automatic logic [`PPC_DATA_W-1:0] anar_view(input ppc_pkg::ppc_ctrl_t c);
    logic [`PPC_DATA_W-1:0] v;
    begin
      v = `PPC_ZERO16;
      v[`PPC_A_PAUSE] = c.adv_pause;
      v[`PPC_A_100FD] = c.adv_100fd;
      v[`PPC_A_100HD] = c.adv_100hd;
      v[`PPC_A_10FD]  = c.adv_10fd;
      v[`PPC_A_10HD]  = c.adv_10hd;
      anar_view = v;
    end
  endfunction

  assign sel = decode(addr);

  // One storage, three write views, so every view always reads back the same bits.
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr)
    begin
      case (sel)
        ppc_pkg::PPC_SEL_PORT: ctrl_next = ppc_pkg::ppc_ctrl_t'(wdata);
        ppc_pkg::PPC_SEL_BCR:
        begin
          ctrl_next.led_off       = wdata[`PPC_B_LED_OFF];
          ctrl_next.tx_dis        = wdata[`PPC_B_TX_DIS];
          ctrl_next.rsvd12        = wdata[`PPC_B_RSVD];
          ctrl_next.mdix_auto_off = wdata[`PPC_B_MDIX_OFF];
          ctrl_next.force_mdix    = wdata[`PPC_B_FORCE_MDIX];
          ctrl_next.force_full    = wdata[`PPC_B_FORCE_FULL];
          ctrl_next.restart_an    = wdata[`PPC_B_RESTART];
          ctrl_next.power_down    = wdata[`PPC_B_PWR_DOWN];
          ctrl_next.an_en         = wdata[`PPC_B_AN_EN];
          ctrl_next.force_100     = wdata[`PPC_B_FORCE_100];
          ctrl_next.far_loop      = wdata[`PPC_B_FAR_LOOP];
        end
        ppc_pkg::PPC_SEL_ANAR:
        begin
          ctrl_next.adv_pause = wdata[`PPC_A_PAUSE];
          ctrl_next.adv_100fd = wdata[`PPC_A_100FD];
          ctrl_next.adv_100hd = wdata[`PPC_A_100HD];
          ctrl_next.adv_10fd  = wdata[`PPC_A_10FD];
          ctrl_next.adv_10hd  = wdata[`PPC_A_10HD];
        end
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ctrl_reg <= ppc_pkg::ppc_ctrl_t'(`PPC_RST_CTRL);
    else if (ce)
      ctrl_reg <= ctrl_next;
  end

  always_comb
  begin
    rdata_next = `PPC_ZERO16;
    if (rd)
    begin
      case (sel)
        ppc_pkg::PPC_SEL_PORT: rdata_next = ctrl_reg;
        ppc_pkg::PPC_SEL_BCR:  rdata_next = bcr_view(ctrl_reg);
        ppc_pkg::PPC_SEL_ANAR: rdata_next = anar_view(ctrl_reg);
        default:               rdata_next = `PPC_ZERO16;
      endcase
    end
  end

  // Read data stand from the enabled edge that takes the strobe until the next enabled edge, and are zero otherwise.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_reg <= `PPC_ZERO16;
    else if (ce)
      rdata_reg <= rdata_next;
  end

  // The stored restart bit is only a record; the PHY acts on this pulse,
  // so writing one again restarts again even if the bit was already set.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      restart_reg <= 1'b0;
    else if (ce)
      restart_reg <= ctrl_next.restart_an && wr && (sel != ppc_pkg::PPC_SEL_NONE) &&
                     (sel != ppc_pkg::PPC_SEL_ANAR);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      led_reg <= {LED_W{1'b1}};
    else if (ce)
      led_reg <= ctrl_reg.led_off ? {LED_W{1'b1}} : led_in;
  end

  // Far-end loopback turns at the PMA: second port receive goes straight back out.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      tx_pair_reg <= {SYM_W{1'b0}};
    else if (ce)
      tx_pair_reg <= ctrl_reg.far_loop ? second_port_receive_pair : port2_tx_normal;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      speed_reg <= 1'b0;
    else if (ce)
      speed_reg <= ctrl_reg.an_en ? an_result.speed_100 : ctrl_reg.force_100;
  end

  // A failed negotiation still has a speed guess from parallel detection,
  // but duplex cannot be detected that way and falls back to the forced value.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      duplex_reg <= 1'b0;
    else if (ce)
      duplex_reg <= (!ctrl_reg.an_en || an_result.failed) ?
                    ctrl_reg.force_full : an_result.duplex_full;
  end

  assign rdata                     = rdata_reg;
  assign port1_led_out             = led_reg;
  assign second_port_transmit_pair = tx_pair_reg;
  assign link_speed_100            = speed_reg;
  assign link_duplex_full          = duplex_reg;
  assign restart_an                = restart_reg;
  assign tx_disable                = ctrl_reg.tx_dis;
  assign power_down                = ctrl_reg.power_down;
  assign auto_mdix_off             = ctrl_reg.mdix_auto_off;
  assign force_mdix                = ctrl_reg.mdix_auto_off && ctrl_reg.force_mdix;
  assign an_enable                 = ctrl_reg.an_en;
  assign advertise.pause           = ctrl_reg.adv_pause;
  assign advertise.fd100           = ctrl_reg.adv_100fd;
  assign advertise.hd100           = ctrl_reg.adv_100hd;
  assign advertise.fd10            = ctrl_reg.adv_10fd;
  assign advertise.hd10            = ctrl_reg.adv_10hd;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_led_blank;
    ce |=> port1_led_out == ($past(ctrl_reg.led_off) ? `PPC_LED_BLANK : $past(led_in));
  endproperty
  a_led_blank: assert property (p_led_blank) else $error("LED pins wrong for blanking bit");

  property p_tx_dis;
    ce && wr && sel == ppc_pkg::PPC_SEL_PORT |=> tx_disable == $past(wdata[`PPC_P_TX_DIS]);
  endproperty
  a_tx_dis: assert property (p_tx_dis) else $error("transmitter disable not taken");

  property p_restart;
    ce && wr && sel == ppc_pkg::PPC_SEL_PORT && wdata[`PPC_P_RESTART] |=> restart_an;
  endproperty
  a_restart: assert property (p_restart) else $error("negotiation restart not pulsed");

  // A frozen clock enable holds the pulse, so only an enabled edge must trace back to a write.
  property p_restart_cause;
    restart_an && $past(ce) |-> $past(wr);
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart without write");

  property p_restart_bcr;
    ce && wr && sel == ppc_pkg::PPC_SEL_BCR && wdata[`PPC_B_RESTART] |=> restart_an;
  endproperty
  a_restart_bcr: assert property (p_restart_bcr) else $error("restart through alias lost");

  property p_mdix_off;
    ce && wr && sel == ppc_pkg::PPC_SEL_PORT |=> auto_mdix_off == $past(wdata[`PPC_P_MDIX_OFF]);
  endproperty
  a_mdix_off: assert property (p_mdix_off) else $error("crossover disable not taken");

  property p_force_mdix;
    force_mdix |-> auto_mdix_off && ctrl_reg.force_mdix;
  endproperty
  a_force_mdix: assert property (p_force_mdix) else $error("MDI-X forced while auto on");

  property p_mdix_write;
    ce && wr && sel == ppc_pkg::PPC_SEL_PORT |=>
      force_mdix == ($past(wdata[`PPC_P_MDIX_OFF]) && $past(wdata[`PPC_P_FORCE_MDIX]));
  endproperty
  a_mdix_write: assert property (p_mdix_write) else $error("MDI-X force not taken");

  property p_far_loop;
    ce && ctrl_reg.far_loop |=> second_port_transmit_pair == $past(second_port_receive_pair);
  endproperty
  a_far_loop: assert property (p_far_loop) else $error("far-end loopback data lost");

  property p_forced_speed;
    ce && !ctrl_reg.an_en |=> link_speed_100 == $past(ctrl_reg.force_100);
  endproperty
  a_forced_speed: assert property (p_forced_speed) else $error("forced speed ignored");

  property p_forced_duplex;
    ce && (!ctrl_reg.an_en || an_result.failed) |=>
      link_duplex_full == $past(ctrl_reg.force_full);
  endproperty
  a_forced_duplex: assert property (p_forced_duplex) else $error("forced duplex ignored");

  property p_an_speed;
    ce && ctrl_reg.an_en |=> link_speed_100 == $past(an_result.speed_100);
  endproperty
  a_an_speed: assert property (p_an_speed) else $error("negotiated speed not used");

  property p_an_duplex;
    ce && ctrl_reg.an_en && !an_result.failed |=>
      link_duplex_full == $past(an_result.duplex_full);
  endproperty
  a_an_duplex: assert property (p_an_duplex) else $error("negotiated duplex not used");

  property p_bcr_alias;
    ce && wr && sel == ppc_pkg::PPC_SEL_BCR ##1 ce && rd && sel == ppc_pkg::PPC_SEL_PORT |=>
      rdata[`PPC_P_LED_OFF] == $past(wdata[`PPC_B_LED_OFF], 2) &&
      rdata[`PPC_P_PWR_DOWN] == $past(wdata[`PPC_B_PWR_DOWN], 2);
  endproperty
  a_bcr_alias: assert property (p_bcr_alias) else $error("basic control alias broken");

  property p_bcr_write;
    ce && wr && sel == ppc_pkg::PPC_SEL_BCR |=>
      an_enable == $past(wdata[`PPC_B_AN_EN]) && tx_disable == $past(wdata[`PPC_B_TX_DIS]);
  endproperty
  a_bcr_write: assert property (p_bcr_write) else $error("basic control write lost");

  property p_readback;
    ce && wr && sel == ppc_pkg::PPC_SEL_PORT ##1 ce && rd && sel == ppc_pkg::PPC_SEL_PORT |=>
      rdata == $past(wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("register does not read back");

  property p_anar_alias;
    ce && wr && sel == ppc_pkg::PPC_SEL_ANAR |=>
      advertise == {$past(wdata[`PPC_A_PAUSE]), $past(wdata[`PPC_A_100FD:`PPC_A_10HD])};
  endproperty
  a_anar_alias: assert property (p_anar_alias) else $error("advertisement alias broken");

  property p_adv_port;
    ce && wr && sel == ppc_pkg::PPC_SEL_PORT |=>
      advertise == $past(wdata[`PPC_P_ADV_HI:`PPC_P_ADV_LO]);
  endproperty
  a_adv_port: assert property (p_adv_port) else $error("adverts wrong");

  property p_pwr_down;
    ce && wr && sel == ppc_pkg::PPC_SEL_PORT |=> power_down == $past(wdata[`PPC_P_PWR_DOWN]);
  endproperty
  a_pwr_down: assert property (p_pwr_down) else $error("power down not taken");

  c_loop: cover property (ce && ctrl_reg.far_loop ##1 ce && !ctrl_reg.far_loop);
  c_restart: cover property (restart_an);
  c_an_fail: cover property (ce && ctrl_reg.an_en && an_result.failed);
  c_alias_rd: cover property (ce && wr && sel == ppc_pkg::PPC_SEL_ANAR ##1 ce && rd);

endmodule // ppc_phy_ctrl
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking testbench for the port PHY control register block.
`include "ppc_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                mclk;
  logic                resetn;
  logic                ce;
  logic                wr;
  logic                rd;
  logic [7:0]          addr;
  logic [15:0]         wdata;
  logic [15:0]         rdata;
  logic [15:0]         rd_val;
  logic [3:0]          led_in;
  logic [3:0]          port1_led_out;
  logic [3:0]          rx_sym;
  logic [3:0]          tx_normal;
  logic [3:0]          tx_sym;
  ppc_pkg::ppc_an_t    an_result;
  ppc_pkg::ppc_adv_t   advertise;
  logic                tx_disable;
  logic                restart_an;
  logic                power_down;
  logic                auto_mdix_off;
  logic                force_mdix;
  logic                an_enable;
  logic                link_speed_100;
  logic                link_duplex_full;
  int                  fail_count;
  int                  comparisons;
  int                  cycles;

  ppc_phy_ctrl dut (
    .mclk                      (mclk),
    .resetn                    (resetn),
    .ce                        (ce),
    .addr                      (addr),
    .wdata                     (wdata),
    .wr                        (wr),
    .rd                        (rd),
    .rdata                     (rdata),
    .led_in                    (led_in),
    .port1_led_out             (port1_led_out),
    .an_result                 (an_result),
    .tx_disable                (tx_disable),
    .restart_an                (restart_an),
    .power_down                (power_down),
    .auto_mdix_off             (auto_mdix_off),
    .force_mdix                (force_mdix),
    .an_enable                 (an_enable),
    .link_speed_100            (link_speed_100),
    .link_duplex_full          (link_duplex_full),
    .advertise                 (advertise),
    .second_port_receive_pair  (rx_sym),
    .port2_tx_normal           (tx_normal),
    .second_port_transmit_pair (tx_sym)
  );

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // The strobe is dropped on the edge that takes the request, so a following call waits a cycle.
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // Write then read with no idle cycle between the strobes, as the bus allows.
  task automatic reg_write_read(input logic [7:0] wa, input logic [15:0] d,
                                input logic [7:0] ra, output logic [15:0] v);
    @(posedge mclk);
    addr  <= wa;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
    addr  <= ra;
    rd    <= 1'b1;
    @(posedge mclk);
    rd    <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  // Registered outputs lag the register by one more edge.
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic link_step(input logic [15:0] w, input ppc_pkg::ppc_an_t an,
                           input logic [2:0] exp);
    reg_write(`PPC_OFS_PORT_CTRL, w);
    an_result <= an;
    settle();
    check("link", {13'h0, an_enable, link_speed_100, link_duplex_full}, {13'h0, exp});
  endtask

  task automatic test_reset();
    check("led rst", {12'h0, port1_led_out}, 16'h000f);
    check("adv rst", {11'h0, advertise}, 16'h001f);
    check("ctl", {12'h0, tx_disable, an_enable, auto_mdix_off, restart_an}, 16'h0004);
    resetn <= 1'b1;
    reg_read(`PPC_OFS_PORT_CTRL, rd_val);
    check("port rst", rd_val, 16'h009f);
    @(posedge mclk);
    #1 check("rdata idle", rdata, 16'h0000);
    reg_read(`PPC_OFS_PHY_BCR, rd_val);
    check("bcr rst", rd_val, 16'h1000);
    reg_read(`PPC_OFS_PHY_ANAR, rd_val);
    check("anar rst", rd_val, 16'h05e0);
    $display("test reset done");
  endtask

  task automatic test_led();
    reg_write(`PPC_OFS_PORT_CTRL, 16'h809f);
    settle();
    check("led blank", {12'h0, port1_led_out}, 16'h000f);
    reg_write(`PPC_OFS_PORT_CTRL, 16'h009f);
    settle();
    check("led normal", {12'h0, port1_led_out}, 16'h0005);
    reg_write_read(`PPC_OFS_PHY_BCR, 16'h0001, `PPC_OFS_PORT_CTRL, rd_val);
    check("bcr alias", rd_val, 16'h801f);
    $display("test led done");
  endtask

  task automatic test_controls();
    logic [15:0] w [5] = '{16'h4000, 16'h0800, 16'h0400, 16'h0200, 16'h0600};
    logic [3:0]  e [5] = '{4'b1000, 4'b0100, 4'b0010, 4'b0000, 4'b0011};
    logic [15:0] ctl;
    for (int i = 0; i < 5; i++)
    begin
      reg_write(`PPC_OFS_PORT_CTRL, w[i]);
      settle();
      ctl = {12'h0, tx_disable, power_down, auto_mdix_off, force_mdix};
      check("controls", ctl, {12'h0, e[i]});
    end
    $display("test controls done");
  endtask

  task automatic test_restart();
    reg_write(`PPC_OFS_PORT_CTRL, 16'h2080);
    #1 check("restart on", {15'h0, restart_an}, 16'h0001);
    @(posedge mclk);
    #1 check("restart off", {15'h0, restart_an}, 16'h0000);
    reg_write(`PPC_OFS_PHY_BCR, 16'h0200);
    #1 check("restart bcr", {15'h0, restart_an}, 16'h0001);
    reg_read(`PPC_OFS_PORT_CTRL, rd_val);
    check("restart view", rd_val, 16'h2000);
    $display("test restart done");
  endtask

  task automatic test_loop();
    reg_write(`PPC_OFS_PORT_CTRL, 16'h0000);
    settle();
    check("tx normal", {12'h0, tx_sym}, 16'h0003);
    reg_write(`PPC_OFS_PORT_CTRL, 16'h0100);
    settle();
    check("tx loop", {12'h0, tx_sym}, 16'h000a);
    @(posedge mclk);
    rx_sym <= 4'h6;
    settle();
    check("tx loop follow", {12'h0, tx_sym}, 16'h0006);
    $display("test loopback done");
  endtask

  task automatic test_link();
    link_step(16'h0060, 3'b000, 3'b011);
    link_step(16'h0000, 3'b011, 3'b000);
    link_step(16'h00a0, 3'b010, 3'b110);
    link_step(16'h00a0, 3'b110, 3'b111);
    link_step(16'h0080, 3'b111, 3'b110);
    $display("test link done");
  endtask

  task automatic test_adv();
    for (int i = 0; i < 5; i++)
    begin
      reg_write(`PPC_OFS_PORT_CTRL, 16'h0001 << i);
      settle();
      check("adv", {11'h0, advertise}, 16'h0001 << i);
      reg_read(`PPC_OFS_PHY_ANAR, rd_val);
      check("anar view", rd_val, (i == 4) ? 16'h0400 : (16'h0020 << i));
    end
    reg_write_read(`PPC_OFS_PHY_ANAR, 16'h0120, `PPC_OFS_PORT_CTRL, rd_val);
    check("anar alias", rd_val, 16'h0009);
    $display("test advertise done");
  endtask

  task automatic test_refuse();
    reg_write_read(`PPC_OFS_PORT_CTRL, 16'h1000, `PPC_OFS_PORT_CTRL, rd_val);
    check("reserved", rd_val, 16'h1000);
    reg_write(8'h10, 16'hffff);
    reg_read(8'h10, rd_val);
    check("unmapped", rd_val, 16'h0000);
    @(posedge mclk);
    ce <= 1'b0;
    reg_write(`PPC_OFS_PORT_CTRL, 16'h4000);
    ce <= 1'b1;
    reg_read(`PPC_OFS_PORT_CTRL, rd_val);
    check("reserved kept", rd_val, 16'h1000);
    $display("test refuse done");
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      fail_count++;
      finish_test();
    end
  end

  initial
  begin
    resetn    = 1'b0;
    ce        = 1'b1;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 8'h00;
    wdata     = 16'h0000;
    led_in    = 4'h5;
    rx_sym    = 4'ha;
    tx_normal = 4'h3;
    an_result = 3'b000;
    cycles    = 0;
    repeat (3) @(posedge mclk);
    test_reset();
    test_led();
    test_controls();
    test_restart();
    test_loop();
    test_link();
    test_adv();
    test_refuse();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
